//--- design/pis_pkg.sv
// package of register map, field positions, reset values and timing counts
package pis_pkg;
    // register byte offsets on the wishbone bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DIS_OFS = 8'h04;
    localparam logic [7:0] ENA_OFS = 8'h08;
    localparam logic [7:0] SRC_EN_OFS = 8'h0C;
    localparam logic [7:0] LABEL_BASE_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h30;
    localparam logic [7:0] PEND_OFS = 8'h34;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h38;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h3C;
    // source count: six external inputs then the timer
    localparam int NUM_EXT = 6;
    localparam int NUM_SRC = 7;
    localparam int TIMER_IDX = 6;
    // control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_TMR_CFG_BIT = 1;
    localparam int CTRL_SEL_LSB = 4;
    localparam int SEL_W = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // status register fields
    localparam int ST_TMR_ACTIVE_BIT = 0;
    localparam int ST_EXEC_ERR_BIT = 1;
    localparam int ST_IN_HANDLER_BIT = 2;
    localparam int ST_DEPTH_LSB = 4;
    // interrupt event bits
    localparam int EV_DISPATCH = 0;
    localparam int EV_EXEC_ERR = 1;
    localparam int EV_RETURN = 2;
    localparam int EV_W = 3;
    // label registers
    localparam int LABEL_W = 16;
    localparam logic [15:0] LABEL_RST = 16'h0000;
    // timer interval: 10 ms steps from 10 ms up to 140 ms
    localparam int TMR_STEP_MS = 10;
    localparam int TMR_MAX_MS = 140;
    localparam logic [SEL_W-1:0] SEL_MAX = 4'hD;
    // subroutine nesting limit inside a handler
    localparam logic [1:0] NEST_MAX = 2'h3;
    // time base: 1 ms at 250 MHz
    localparam int CLK_MHZ = 250;
    localparam int MS_US = 1000;
    localparam int MS_CYCLES = CLK_MHZ * MS_US;
    // dispatch state machine
    typedef enum logic [0:0] {
        PIS_IDLE = 1'b0,
        PIS_HANDLER = 1'b1
    } pis_state_e;
endpackage

//--- design/pis_tick_if.sv
// interface carrying the millisecond time-base enable between modules
`timescale 1ns/1ps
`default_nettype none
interface pis_tick_if;
    logic run; // count only while running
    logic ms_tick; // one-cycle pulse per millisecond
    modport source (input run, output ms_tick);
    modport sink (output run, input ms_tick);
endinterface
`default_nettype wire

//--- design/pis_ms_tick.sv
// divider producing a one-cycle millisecond enable pulse
`timescale 1ns/1ps
`default_nettype none
module pis_ms_tick #(
    parameter int DIV = pis_pkg::MS_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    pis_tick_if.source tick
);
    logic [17:0] cnt_q; // cycle counter within one millisecond
    logic [17:0] cnt_d;
    logic tick_q; // registered tick pulse
    logic tick_d;

    // next count; restarts when not running so intervals start fresh
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!tick.run) begin
            cnt_d = 18'h00000;
        end else if (cnt_q == 18'(DIV - 1)) begin
            cnt_d = 18'h00000;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 18'h00001;
        end
    end

    // register the divider
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q <= 18'h00000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick.ms_tick = tick_q;
endmodule
`default_nettype wire

//--- design/pis_top.sv
// periodic timer interrupt and handler dispatch unit with wishbone registers
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - timer period selectable 10 to 140 ms
// - in run, timer dispatches to its label
// - label return resumes at interrupted address
// - sources enabled at run; disable/enable instructions
// - timer active flag mirrors timer enable
// - over three nested calls raises error
// - every source has own label register
// - requests wait; one handler at a time
// - external inputs use rising physical edges only
module pis_top #(
    parameter int MS_DIV = pis_pkg::MS_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    // wishbone classic slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // execution core side
    input wire logic [pis_pkg::NUM_EXT-1:0] ext_irq_in,
    input wire logic [15:0] pc_in,
    input wire logic call_in,
    input wire logic sub_ret_in,
    input wire logic label_return_in,
    output logic dispatch_out,
    output logic [15:0] dispatch_label_out,
    output logic resume_out,
    output logic [15:0] resume_addr_out,
    output logic err_led_out,
    output logic irq_out
);
    localparam int N = pis_pkg::NUM_SRC;

    pis_tick_if tick_bus ();

    pis_ms_tick #(.DIV(MS_DIV)) u_tick (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tick(tick_bus.source)
    );

    // register state
    logic [31:0] ctrl_q; // run, timer config enable, interval select
    logic [31:0] ctrl_d;
    logic [N-1:0] en_q; // per-source enable
    logic [N-1:0] en_d;
    logic [15:0] label_q [N]; // per-source handler labels
    logic [15:0] label_d [N];
    logic [pis_pkg::EV_W-1:0] ev_stat_q; // sticky event bits
    logic [pis_pkg::EV_W-1:0] ev_stat_d;
    logic [pis_pkg::EV_W-1:0] ev_mask_q; // event mask
    logic [pis_pkg::EV_W-1:0] ev_mask_d;
    logic err_q; // program execution error flag
    logic err_d;
    logic ack_q; // wishbone acknowledge
    logic ack_d;
    logic [31:0] rdat_q; // read data
    logic [31:0] rdat_d;
    // dispatch state
    pis_pkg::pis_state_e st_q;
    pis_pkg::pis_state_e st_d;
    logic [N-1:0] pend_q; // pending request per source
    logic [N-1:0] pend_d;
    logic [N-1:0] ext_prev_q; // previous input level for edge detection
    logic [15:0] ret_q; // return address captured at dispatch
    logic [15:0] ret_d;
    logic [1:0] depth_q; // subroutine nesting depth in handler
    logic [1:0] depth_d;
    logic [7:0] ms_cnt_q; // elapsed ms in current interval
    logic [7:0] ms_cnt_d;
    logic run_prev_q; // run level one cycle ago
    logic disp_q;
    logic disp_d;
    logic res_q;
    logic res_d;
    logic [15:0] dlab_q;
    logic [15:0] dlab_d;

    // decoded helpers
    logic run;
    logic acc;
    logic wr;
    logic [31:0] wmask;
    logic [pis_pkg::SEL_W-1:0] sel;
    logic [7:0] period_ms;
    logic tmr_go;
    logic tmr_expire;
    logic [N-1:0] req;
    logic [N-1:0] avail;
    logic grant;
    logic [2:0] gidx;
    logic nest_err;

    assign run = ctrl_q[pis_pkg::CTRL_RUN_BIT];
    assign acc = wb_cyc_in && wb_stb_in && !ack_q;
    assign wr = acc && wb_we_in;
    assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    assign tick_bus.run = tmr_go;

    // interval select clamps to the top step
    always_comb begin
        sel = ctrl_q[pis_pkg::CTRL_SEL_LSB +: pis_pkg::SEL_W];
        if (sel > pis_pkg::SEL_MAX) begin
            sel = pis_pkg::SEL_MAX;
        end
        period_ms = 8'(({4'h0, sel} + 8'h01) * 8'(pis_pkg::TMR_STEP_MS));
    end

    // timer runs only while running with both the setting and source enabled
    assign tmr_go = run && ctrl_q[pis_pkg::CTRL_TMR_CFG_BIT] && en_q[pis_pkg::TIMER_IDX];
    assign tmr_expire = tmr_go && tick_bus.ms_tick && (ms_cnt_q == period_ms - 8'h01);

    // raw requests: rising physical edges and timer expiry
    always_comb begin
        req = '0;
        req[pis_pkg::NUM_EXT-1:0] = ext_irq_in & ~ext_prev_q[pis_pkg::NUM_EXT-1:0];
        req[pis_pkg::TIMER_IDX] = tmr_expire;
    end

    // lowest index enabled pending source wins
    always_comb begin
        avail = pend_q & en_q;
        grant = 1'b0;
        gidx = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (avail[i]) begin
                grant = 1'b1;
                gidx = 3'(i);
            end
        end
    end

    assign nest_err = (st_q == pis_pkg::PIS_HANDLER) && call_in && (depth_q == pis_pkg::NEST_MAX);

    // millisecond interval counter
    always_comb begin
        ms_cnt_d = ms_cnt_q;
        if (!tmr_go) begin
            ms_cnt_d = 8'h00;
        end else if (tick_bus.ms_tick) begin
            ms_cnt_d = tmr_expire ? 8'h00 : ms_cnt_q + 8'h01;
        end
    end

    // dispatch state machine, pending flags and nesting depth
    always_comb begin
        st_d = st_q;
        pend_d = pend_q;
        ret_d = ret_q;
        depth_d = depth_q;
        disp_d = 1'b0;
        res_d = 1'b0;
        dlab_d = dlab_q;
        if (!run) begin
            st_d = pis_pkg::PIS_IDLE;
            pend_d = '0;
            depth_d = 2'h0;
        end else begin
            case (st_q)
                pis_pkg::PIS_IDLE: begin
                    if (grant) begin
                        st_d = pis_pkg::PIS_HANDLER;
                        pend_d[gidx] = 1'b0;
                        ret_d = pc_in;
                        dlab_d = label_q[gidx];
                        disp_d = 1'b1;
                        depth_d = 2'h0;
                    end
                end
                pis_pkg::PIS_HANDLER: begin
                    // requests wait here until the handler returns
                    if (label_return_in) begin
                        st_d = pis_pkg::PIS_IDLE;
                        res_d = 1'b1;
                        depth_d = 2'h0;
                    end else if (call_in && depth_q != pis_pkg::NEST_MAX) begin
                        depth_d = depth_q + 2'h1;
                    end else if (sub_ret_in && depth_q != 2'h0) begin
                        depth_d = depth_q - 2'h1;
                    end
                end
                default: begin
                    st_d = pis_pkg::PIS_IDLE;
                end
            endcase
            // new requests set after the dispatch clear, so they win; repeats collapse
            pend_d = pend_d | (req & en_q);
        end
    end

    // register file next values and wishbone access
    always_comb begin
        ctrl_d = ctrl_q;
        en_d = en_q;
        label_d = label_q;
        ev_mask_d = ev_mask_q;
        ev_stat_d = ev_stat_q;
        err_d = err_q;
        ack_d = acc;
        rdat_d = rdat_q;
        // sources come back enabled whenever run starts
        if (run && !run_prev_q) begin
            en_d = '1;
        end
        if (wr) begin
            case (wb_adr_in)
                pis_pkg::CTRL_OFS: ctrl_d = (ctrl_q & ~wmask) | (wb_dat_in & wmask);
                pis_pkg::DIS_OFS: en_d = en_d & ~(wb_dat_in[N-1:0] & wmask[N-1:0]);
                pis_pkg::ENA_OFS: en_d = en_d | (wb_dat_in[N-1:0] & wmask[N-1:0]);
                pis_pkg::STATUS_OFS: begin
                    if (wb_sel_in[0] && wb_dat_in[pis_pkg::ST_EXEC_ERR_BIT]) begin
                        err_d = 1'b0;
                    end
                end
                pis_pkg::IRQ_STAT_OFS: begin
                    if (wb_sel_in[0]) begin
                        ev_stat_d = ev_stat_q & ~wb_dat_in[pis_pkg::EV_W-1:0];
                    end
                end
                pis_pkg::IRQ_MASK_OFS: begin
                    if (wb_sel_in[0]) begin
                        ev_mask_d = wb_dat_in[pis_pkg::EV_W-1:0];
                    end
                end
                default: begin
                    // label registers; other addresses ignore writes
                    for (int i = 0; i < N; i++) begin
                        if (wb_adr_in == pis_pkg::LABEL_BASE_OFS + 8'(4 * i)) begin
                            label_d[i] = (label_q[i] & ~wmask[15:0])
                                | (wb_dat_in[15:0] & wmask[15:0]);
                        end
                    end
                end
            endcase
        end
        // hardware sets win over software clears
        if (nest_err) begin
            err_d = 1'b1;
        end
        ev_stat_d[pis_pkg::EV_DISPATCH] = ev_stat_d[pis_pkg::EV_DISPATCH] | disp_d;
        ev_stat_d[pis_pkg::EV_EXEC_ERR] = ev_stat_d[pis_pkg::EV_EXEC_ERR] | nest_err;
        ev_stat_d[pis_pkg::EV_RETURN] = ev_stat_d[pis_pkg::EV_RETURN] | res_d;
        // read mux
        if (acc && !wb_we_in) begin
            rdat_d = 32'h0000_0000;
            case (wb_adr_in)
                pis_pkg::CTRL_OFS: rdat_d = ctrl_q;
                pis_pkg::SRC_EN_OFS: rdat_d[N-1:0] = en_q;
                pis_pkg::STATUS_OFS: begin
                    rdat_d[pis_pkg::ST_TMR_ACTIVE_BIT] = en_q[pis_pkg::TIMER_IDX];
                    rdat_d[pis_pkg::ST_EXEC_ERR_BIT] = err_q;
                    rdat_d[pis_pkg::ST_IN_HANDLER_BIT] = (st_q == pis_pkg::PIS_HANDLER);
                    rdat_d[pis_pkg::ST_DEPTH_LSB +: 2] = depth_q;
                end
                pis_pkg::PEND_OFS: rdat_d[N-1:0] = pend_q;
                pis_pkg::IRQ_STAT_OFS: rdat_d[pis_pkg::EV_W-1:0] = ev_stat_q;
                pis_pkg::IRQ_MASK_OFS: rdat_d[pis_pkg::EV_W-1:0] = ev_mask_q;
                default: begin
                    for (int i = 0; i < N; i++) begin
                        if (wb_adr_in == pis_pkg::LABEL_BASE_OFS + 8'(4 * i)) begin
                            rdat_d[15:0] = label_q[i];
                        end
                    end
                end
            endcase
        end
    end

    // register all state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_q <= pis_pkg::CTRL_RST;
            en_q <= '1;
            for (int i = 0; i < N; i++) begin
                label_q[i] <= pis_pkg::LABEL_RST;
            end
            ev_stat_q <= '0;
            ev_mask_q <= '0;
            err_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            st_q <= pis_pkg::PIS_IDLE;
            pend_q <= '0;
            ext_prev_q <= '0;
            ret_q <= 16'h0000;
            depth_q <= 2'h0;
            ms_cnt_q <= 8'h00;
            run_prev_q <= 1'b0;
            disp_q <= 1'b0;
            res_q <= 1'b0;
            dlab_q <= 16'h0000;
        end else begin
            ctrl_q <= ctrl_d;
            en_q <= en_d;
            label_q <= label_d;
            ev_stat_q <= ev_stat_d;
            ev_mask_q <= ev_mask_d;
            err_q <= err_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            st_q <= st_d;
            pend_q <= pend_d;
            ext_prev_q <= {1'b0, ext_irq_in};
            ret_q <= ret_d;
            depth_q <= depth_d;
            ms_cnt_q <= ms_cnt_d;
            run_prev_q <= run;
            disp_q <= disp_d;
            res_q <= res_d;
            dlab_q <= dlab_d;
        end
    end

    // outputs
    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;
    assign dispatch_out = disp_q;
    assign dispatch_label_out = dlab_q;
    assign resume_out = res_q;
    assign resume_addr_out = ret_q;
    assign err_led_out = err_q;
    assign irq_out = |(ev_stat_q & ev_mask_q);
endmodule
`default_nettype wire

//--- verif/pis_top_chk.sv
// checker of bus answer, dispatch, return and nesting error at the ports
`timescale 1ns/1ps
`default_nettype none
module pis_top_chk #(
    parameter int MS_DIV = pis_pkg::MS_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic [15:0] pc_in,
    input wire logic call_in,
    input wire logic sub_ret_in,
    input wire logic label_return_in,
    input wire logic dispatch_out,
    input wire logic [15:0] dispatch_label_out,
    input wire logic resume_out,
    input wire logic [15:0] resume_addr_out,
    input wire logic err_led_out
);
    logic in_h_q, in_h_d; // a handler is running
    logic [2:0] depth_q, depth_d; // call depth inside the handler
    logic [15:0] pc_q, pc_d; // address to come back to
    logic [15:0] pcp_q, pcp_d; // pc one cycle back, taken at the deciding edge
    // next state of the handler tracker
    always_comb begin
        in_h_d = in_h_q;
        depth_d = depth_q;
        pc_d = pc_q;
        pcp_d = pc_in;
        if (dispatch_out) begin
            in_h_d = 1'b1;
            depth_d = 3'h0;
            pc_d = pcp_q;
        end else if (resume_out) begin
            in_h_d = 1'b0;
            depth_d = 3'h0;
        end else if (call_in && in_h_q && depth_q < 3'h3) begin
            depth_d = depth_q + 3'h1;
        end else if (sub_ret_in && depth_q != 3'h0) begin
            depth_d = depth_q - 3'h1;
        end
    end
    // registers of the tracker
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            in_h_q <= 1'b0;
            depth_q <= 3'h0;
            pc_q <= 16'h0000;
            pcp_q <= 16'h0000;
        end else begin
            in_h_q <= in_h_d;
            depth_q <= depth_d;
            pc_q <= pc_d;
            pcp_q <= pcp_d;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in) && $past(wb_stb_in))
        else $error("ack without request");
    a_disp_pulse: assert property (dispatch_out |=> !dispatch_out)
        else $error("dispatch longer than one cycle");
    a_one_handler: assert property (dispatch_out |-> !in_h_q || resume_out)
        else $error("dispatch while a handler runs");
    a_resume_prompt: assert property (label_return_in && in_h_q && !resume_out |=> resume_out)
        else $error("label return not followed by resume");
    a_resume_addr: assert property (resume_out |-> resume_addr_out == pc_q)
        else $error("resume address differs from interrupted address");
    a_resume_cause: assert property (resume_out |-> $past(label_return_in))
        else $error("resume without label return");
    a_label_hold: assert property (!dispatch_out |-> $stable(dispatch_label_out))
        else $error("dispatch label moved without dispatch");
    a_err_set: assert property (call_in && in_h_q && !resume_out && depth_q == 3'h3 |=> err_led_out)
        else $error("fourth nested call did not raise error");
    a_err_cause: assert property ($rose(err_led_out) |-> $past(call_in) && $past(depth_q) == 3'h3)
        else $error("error raised without too deep call");
    cover property (dispatch_out);
    cover property (resume_out);
    cover property ($rose(err_led_out));
endmodule
bind pis_top pis_top_chk #(.MS_DIV(MS_DIV)) pis_top_chk_inst (.clk_in(clk_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .pc_in(pc_in),
    .call_in(call_in), .sub_ret_in(sub_ret_in), .label_return_in(label_return_in),
    .dispatch_out(dispatch_out), .dispatch_label_out(dispatch_label_out),
    .resume_out(resume_out), .resume_addr_out(resume_addr_out), .err_led_out(err_led_out));
`default_nettype wire

//--- verif/pis_top_tb.sv
// self-checking bench of the scheduler: registers, dispatch, timer, nesting
`timescale 1ns/1ps
`default_nettype none
module pis_top_tb;
    localparam int DIV = 10; // short millisecond for simulation
    logic clk_in = 1'b0; // 250 MHz clock
    logic rst_in = 1'b1; // synchronous reset
    logic cyc_q = 1'b0; // bus cycle and strobe
    logic we_q = 1'b0; // bus direction
    logic [7:0] adr_q = 8'h00; // bus address
    logic [31:0] wdat_q = 32'h0; // bus write data
    logic [5:0] ext_q = 6'h00; // external interrupt levels
    logic [15:0] pc_q = 16'h0000; // main program address
    logic [2:0] ctl_q = 3'h0; // call, sub return, label return pulses
    logic [31:0] rd; // last read word
    wire logic [31:0] dat;
    wire logic ack, disp, res, led, irq;
    wire logic [15:0] lbl_o, ra;
    int err_total = 0, checks = 0, seed = 32'h641AAD14, cyc_n = 0, t0;
    int lbl[7]; // model of the label registers
    int srcq[$]; // model of the held requests in service order
    int sels[3] = '{0, 13, 15}; // interval selections, 15 above the top
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) cyc_n <= cyc_n + 1;
    pis_top #(.MS_DIV(DIV)) pis_top_inst (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc_q),
        .wb_stb_in(cyc_q), .wb_we_in(we_q), .wb_adr_in(adr_q), .wb_sel_in(4'hF),
        .wb_dat_in(wdat_q), .wb_dat_out(dat), .wb_ack_out(ack), .ext_irq_in(ext_q),
        .pc_in(pc_q), .call_in(ctl_q[2]), .sub_ret_in(ctl_q[1]), .label_return_in(ctl_q[0]),
        .dispatch_out(disp), .dispatch_label_out(lbl_o), .resume_out(res),
        .resume_addr_out(ra), .err_led_out(led), .irq_out(irq));
    // compare one value and count it
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_in);
        cyc_q <= 1'b1;
        we_q <= w;
        adr_q <= a;
        wdat_q <= d;
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat;
        cyc_q <= 1'b0;
        we_q <= 1'b0;
        if (n >= 20) chk("bus ack", 32'h0, 32'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask
    // wait for dispatch (0) or resume (1) under a bound
    task automatic wait_on(input int which, input int lim);
        int n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while ((which ? res : disp) !== 1'b1 && n < lim);
        if (n >= lim) chk("pulse wait", 32'h0, 32'h1);
    endtask
    task automatic pulse(input logic [2:0] v);
        @(posedge clk_in);
        ctl_q <= v;
        @(posedge clk_in);
        ctl_q <= 3'h0;
    endtask
    task automatic disp_chk(input int src, input int lim);
        wait_on(0, lim);
        chk("label", {16'h0, lbl_o}, lbl[src][31:0]);
    endtask
    task automatic ret_chk(input logic [15:0] pc);
        pulse(3'h1);
        wait_on(1, 10);
        chk("resume addr", {16'h0, ra}, {16'h0, pc});
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk_in);
            chk("no dispatch", {31'h0, disp}, 32'h0);
        end
    endtask
    task automatic finish_test;
        $display("counts: %0d checks, %0d mismatches", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (40000) @(posedge clk_in);
        err_total++;
        finish_test();
    end
    // main sequence
    initial begin
        logic [15:0] pcv;
        int exp_iv;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        rdchk("ctrl", pis_pkg::CTRL_OFS, pis_pkg::CTRL_RST);
        rdchk("enables", pis_pkg::SRC_EN_OFS, 32'h7F);
        wr(8'hFC, 32'hFFFF);
        rdchk("unmapped", 8'hFC, 32'h0);
        for (int i = 0; i < 7; i++) begin
            lbl[i] = $random(seed) & 32'hFFFF;
            wr(pis_pkg::LABEL_BASE_OFS + 8'(4 * i), lbl[i]);
        end
        for (int i = 0; i < 7; i++)
            rdchk("label reg", pis_pkg::LABEL_BASE_OFS + 8'(4 * i), lbl[i]);
        $display("test registers end");
        wr(pis_pkg::CTRL_OFS, 32'h1);
        for (int i = 0; i < 6; i++) begin
            pcv = 16'($random(seed));
            pc_q <= pcv;
            ext_q <= 6'(1 << i);
            disp_chk(i, 20);
            ret_chk(pcv);
            ext_q <= 6'h00;
            @(posedge clk_in);
        end
        rdchk("events", pis_pkg::IRQ_STAT_OFS, 32'h5);
        wr(pis_pkg::IRQ_MASK_OFS, 32'h1);
        repeat (2) @(posedge clk_in);
        chk("irq on", {31'h0, irq}, 32'h1);
        wr(pis_pkg::IRQ_MASK_OFS, 32'h0);
        repeat (2) @(posedge clk_in);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(pis_pkg::IRQ_MASK_OFS, 32'h1);
        wr(pis_pkg::IRQ_STAT_OFS, 32'h7);
        repeat (2) @(posedge clk_in);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        $display("test external dispatch end");
        ext_q <= 6'h08;
        srcq.push_back(3);
        disp_chk(srcq.pop_front(), 20);
        ext_q <= 6'h0A;
        srcq.push_back(1);
        repeat (2) @(posedge clk_in);
        ext_q <= 6'h08;
        @(posedge clk_in);
        ext_q <= 6'h0A;
        quiet(10);
        rdchk("pending", pis_pkg::PEND_OFS, 32'h2);
        pulse(3'h4);
        pulse(3'h4);
        pulse(3'h4);
        pulse(3'h2);
        pulse(3'h4);
        bus(1'b0, pis_pkg::STATUS_OFS, 32'h0);
        chk("depth", {30'h0, rd[5:4]}, 32'h3);
        chk("led quiet", {31'h0, led}, 32'h0);
        pulse(3'h4);
        @(posedge clk_in);
        chk("led", {31'h0, led}, 32'h1);
        bus(1'b0, pis_pkg::STATUS_OFS, 32'h0);
        chk("exec error", {31'h0, rd[1]}, 32'h1);
        rdchk("events err", pis_pkg::IRQ_STAT_OFS, 32'h3);
        wr(pis_pkg::STATUS_OFS, 32'h2);
        chk("led cleared", {31'h0, led}, 32'h0);
        ret_chk(pcv);
        disp_chk(srcq.pop_front(), 20);
        ret_chk(pcv);
        quiet(30);
        ext_q <= 6'h00;
        $display("test queue and nesting end");
        wr(pis_pkg::DIS_OFS, 32'h4);
        ext_q <= 6'h04;
        quiet(10);
        rdchk("enables off", pis_pkg::SRC_EN_OFS, 32'h7B);
        wr(pis_pkg::ENA_OFS, 32'h4);
        rdchk("enables on", pis_pkg::SRC_EN_OFS, 32'h7F);
        wr(pis_pkg::DIS_OFS, 32'h41);
        wr(pis_pkg::CTRL_OFS, 32'h0);
        wr(pis_pkg::CTRL_OFS, 32'h1);
        rdchk("run restart", pis_pkg::SRC_EN_OFS, 32'h7F);
        ext_q <= 6'h00;
        wr(pis_pkg::CTRL_OFS, 32'hD3);
        rdchk("timer flag", pis_pkg::SRC_EN_OFS, 32'h7F);
        bus(1'b0, pis_pkg::STATUS_OFS, 32'h0);
        chk("active set", {31'h0, rd[0]}, 32'h1);
        wr(pis_pkg::DIS_OFS, 32'h40);
        bus(1'b0, pis_pkg::STATUS_OFS, 32'h0);
        chk("active clear", {31'h0, rd[0]}, 32'h0);
        wr(pis_pkg::ENA_OFS, 32'h40);
        bus(1'b0, pis_pkg::STATUS_OFS, 32'h0);
        chk("active again", {31'h0, rd[0]}, 32'h1);
        wr(pis_pkg::CTRL_OFS, 32'h1);
        foreach (sels[k]) begin
            wr(pis_pkg::CTRL_OFS, 32'(sels[k] * 16 + 3));
            disp_chk(6, 1500);
            t0 = cyc_n;
            ret_chk(pcv);
            disp_chk(6, 1500);
            exp_iv = (sels[k] > int'(pis_pkg::SEL_MAX) ? int'(pis_pkg::SEL_MAX) : sels[k]) + 1;
            chk("interval", 32'(cyc_n - t0), 32'(exp_iv * pis_pkg::TMR_STEP_MS * DIV));
            ret_chk(pcv);
            wr(pis_pkg::CTRL_OFS, 32'h1);
        end
        $display("test timer end");
        finish_test();
    end
endmodule
`default_nettype wire
